// ===== hdl/wake_frame_cfg.sv
// selective wake frame mask, length code and payload byte 7..3 registers
// with the frame comparison that uses them.
// assumes request, frame and expected-identifier inputs come from logic on clk_sys.
`timescale 1ns/10ps

// Contract
// - a mask bit of one compares that identifier bit, zero ignores it
// - highest mask register holds identifier mask bits 28..21 in 7..0
// - next registers hold mask bits 20..13 and 12..5 in 7..0
// - lowest mask register holds bits 4..0 in 6..2; 7,1,0 read zero
// - length code is four bits; codes 8 to 15 all mean eight bytes
// - received length code must equal configured code in every bit
// - length code register bits 7..4 always read back zero
// - each payload byte register stores one full byte, bit 0 lsb
// - power-on or soft reset clears every register here to zero
// - restart forces reserved bits zero; other bits keep their value
// - standard frames compare only mask bits for identifier 28..18
// - changing any configuration register clears the configuration-valid flag
module wake_frame_cfg
  import wake_cfg_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         srst,
  input  wire logic         restart,
  input  wire reg_req_type  reg_req,
  output logic [7:0]        reg_rdata,
  input  wire logic         config_valid_set,
  output logic              config_valid_flag,
  input  wire logic [28:0]  expected_id,
  input  wire logic         expected_ide,
  input  wire logic         low_bytes_match,
  input  wire logic         frame_done,
  input  wire rx_frame_type rx_frame,
  output logic              wake_up_frame_match
);

  // ****************************************
  // state
  // ****************************************
  logic [28:0] id_compare_sel;
  logic [3:0]  dlc_cfg;
  logic [7:0]  payload [first_local_byte:last_local_byte];
  logic [28:0] next_id_compare_sel;
  logic [3:0]  next_dlc_cfg;
  logic [7:0]  next_payload [first_local_byte:last_local_byte];
  logic [7:0]  next_reg_rdata;
  logic        next_config_valid_flag;
  logic        next_match;
  logic [7:0]  cur_value;
  logic [7:0]  new_value;
  logic        cfg_changed;
  logic        id_ok;
  logic        data_ok;
  logic [3:0]  frame_len;

  // read view of one register; reserved bits always zero
  function automatic logic [7:0] reg_view(input logic [6:0] a, input logic [28:0] m,
                                          input logic [3:0] d, input logic [7:0] p3,
                                          input logic [7:0] p4, input logic [7:0] p5,
                                          input logic [7:0] p6, input logic [7:0] p7);
    case (a)
      wake_id_mask_high:      reg_view = m[28:21];
      wake_id_mask_upper_mid: reg_view = m[20:13];
      wake_id_mask_lower_mid: reg_view = m[12:5];
      wake_id_mask_low:       reg_view = {1'b0, m[4:0], 2'b00};
      wake_length_code:       reg_view = {4'h0, d};
      wake_payload_byte_7:    reg_view = p7;
      wake_payload_byte_6:    reg_view = p6;
      wake_payload_byte_5:    reg_view = p5;
      wake_payload_byte_4:    reg_view = p4;
      wake_payload_byte_3:    reg_view = p3;
      default:                reg_view = reg_reset_value;
    endcase
  endfunction

  // payload byte held here that sits at register address a
  function automatic int byte_of(input logic [6:0] a);
    byte_of = last_local_byte - int'(a - wake_payload_byte_7);
  endfunction

  // ****************************************
  // next values
  // ****************************************
  always_comb begin
    next_id_compare_sel = id_compare_sel;
    next_dlc_cfg        = dlc_cfg;
    next_payload        = payload;
    cur_value = reg_view(reg_req.addr, id_compare_sel, dlc_cfg, payload[3], payload[4],
                         payload[5], payload[6], payload[7]);
    // only bits that are stored can change; a reserved-bit write is no change
    case (reg_req.addr)
      wake_id_mask_low: new_value = reg_req.wdata & mask_low_keep;
      wake_length_code: new_value = reg_req.wdata & dlc_keep;
      default:          new_value = reg_req.wdata;
    endcase
    cfg_changed = 1'b0;
    if (reg_req.wr) begin
      case (reg_req.addr)
        wake_id_mask_high:      next_id_compare_sel[28:21] = reg_req.wdata;
        wake_id_mask_upper_mid: next_id_compare_sel[20:13] = reg_req.wdata;
        wake_id_mask_lower_mid: next_id_compare_sel[12:5]  = reg_req.wdata;
        wake_id_mask_low:
          next_id_compare_sel[4:0] = reg_req.wdata[mask_low_msb:mask_low_lsb];
        wake_length_code:       next_dlc_cfg = reg_req.wdata[dlc_msb:0];
        default: begin
          if (reg_req.addr >= wake_payload_byte_7 && reg_req.addr <= wake_payload_byte_3)
            next_payload[byte_of(reg_req.addr)] = reg_req.wdata;
        end
      endcase
      if (reg_req.addr >= wake_id_mask_high && reg_req.addr <= wake_payload_byte_3)
        cfg_changed = (new_value != cur_value);
    end
    next_reg_rdata = reg_req.rd ? cur_value : reg_rdata;

    // identifier: standard frames use only identifier bits 28..18
    id_ok = (rx_frame.extended_id_select == expected_ide);
    for (int i = 0; i < id_width; i++) begin
      if (id_compare_sel[i] && (expected_ide || i >= std_id_lsb) &&
          rx_frame.id[i] != expected_id[i])
        id_ok = 1'b0;
    end
    frame_len = (dlc_cfg >= dlc_full_length) ? dlc_full_length : dlc_cfg;
    data_ok = low_bytes_match;
    for (int b = first_local_byte; b <= last_local_byte; b++) begin
      if (4'(b) < frame_len && rx_frame.data[b*8 +: 8] != payload[b])
        data_ok = 1'b0;
    end
    next_match = frame_done && config_valid_flag && id_ok && data_ok &&
                 (rx_frame.dlc == dlc_cfg);

    // a change or a wake clears the flag and wins over software setting it
    if (cfg_changed || next_match)
      next_config_valid_flag = 1'b0;
    else if (config_valid_set)
      next_config_valid_flag = 1'b1;
    else
      next_config_valid_flag = config_valid_flag;
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      id_compare_sel      <= '0;
      dlc_cfg             <= '0;
      for (int b = first_local_byte; b <= last_local_byte; b++) begin
        payload[b] <= reg_reset_value;
      end
      reg_rdata           <= reg_reset_value;
      config_valid_flag   <= 1'b0;
      wake_up_frame_match <= 1'b0;
    end else if (restart) begin
      // reserved bits are not stored, so they stay zero; mask, length and payload keep their values, read data, flag and match clear
      reg_rdata           <= reg_reset_value;
      config_valid_flag   <= 1'b0;
      wake_up_frame_match <= 1'b0;
    end else begin
      id_compare_sel      <= next_id_compare_sel;
      dlc_cfg             <= next_dlc_cfg;
      payload             <= next_payload;
      reg_rdata           <= next_reg_rdata;
      config_valid_flag   <= next_config_valid_flag;
      wake_up_frame_match <= next_match;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst || restart);

  sequence write_to(logic [6:0] a);
    reg_req.wr && reg_req.addr == a;
  endsequence
  sequence read_of(logic [6:0] a);
    reg_req.rd && !reg_req.wr && reg_req.addr == a;
  endsequence

  mask_low_reserved_a: assert property (
    write_to(wake_id_mask_low) ##1 !reg_req.wr ##1 read_of(wake_id_mask_low)
      |=> reg_rdata[7] == 1'b0
      && reg_rdata[1:0] == 2'b00 && reg_rdata[6:2] == $past(reg_req.wdata[6:2], 3))
    else $error("low mask register reserved bits or field wrong");
  dlc_upper_zero_a: assert property (
    read_of(wake_length_code) |=> reg_rdata[7:4] == 4'h0 && reg_rdata[3:0] == dlc_cfg)
    else $error("length code readback wrong");
  mask_high_store_a: assert property (
    write_to(wake_id_mask_high) |=> id_compare_sel[28:21] == $past(reg_req.wdata))
    else $error("highest mask register not stored");
  mask_mid_store_a: assert property (
    write_to(wake_id_mask_lower_mid) |=> id_compare_sel[12:5] == $past(reg_req.wdata))
    else $error("lower middle mask register not stored");
  payload_full_byte_a: assert property (
    write_to(wake_payload_byte_3) ##1 !reg_req.wr ##1 read_of(wake_payload_byte_3)
      |=> reg_rdata == $past(reg_req.wdata, 3))
    else $error("payload byte 3 did not read back");
  change_clears_a: assert property (
    reg_req.wr && cfg_changed |=> !config_valid_flag)
    else $error("configuration change left flag set");
  dlc_exact_a: assert property (
    frame_done && rx_frame.dlc != dlc_cfg |=> !wake_up_frame_match)
    else $error("match with unequal length code");
  ide_mismatch_a: assert property (
    frame_done && rx_frame.extended_id_select != expected_ide |=> !wake_up_frame_match)
    else $error("match with wrong identifier length");
  id_compare_a: assert property (
    frame_done && expected_ide && ((rx_frame.id ^ expected_id) & id_compare_sel) != '0
      |=> !wake_up_frame_match)
    else $error("match despite compared identifier bit differing");
  std_ignore_a: assert property (
    frame_done && config_valid_flag && !expected_ide && !rx_frame.extended_id_select && low_bytes_match
      && rx_frame.dlc == dlc_cfg && dlc_cfg <= 4'h3
      && ((rx_frame.id ^ expected_id) & id_compare_sel & 29'h1ffc0000) == '0
      |=> wake_up_frame_match)
    else $error("standard frame match missed");
  match_clears_a: assert property (
    wake_up_frame_match |=> !config_valid_flag)
    else $error("flag not cleared after wake");

endmodule

// ===== hdl/wake_cfg_pkg.sv
// package for the selective wake frame configuration registers
// assumes an 8-bit register port from the device's serial command decoder
package wake_cfg_pkg;

  // ****************************************
  // register offsets (7-bit register addresses)
  // ****************************************
  localparam logic [6:0] wake_id_mask_high       = 7'h27;
  localparam logic [6:0] wake_id_mask_upper_mid  = 7'h28;
  localparam logic [6:0] wake_id_mask_lower_mid  = 7'h29;
  localparam logic [6:0] wake_id_mask_low        = 7'h2a;
  localparam logic [6:0] wake_length_code        = 7'h2b;
  localparam logic [6:0] wake_payload_byte_7     = 7'h2c;
  localparam logic [6:0] wake_payload_byte_6     = 7'h2d;
  localparam logic [6:0] wake_payload_byte_5     = 7'h2e;
  localparam logic [6:0] wake_payload_byte_4     = 7'h2f;
  localparam logic [6:0] wake_payload_byte_3     = 7'h30;

  // ****************************************
  // field layout and reset values
  // ****************************************
  localparam int          id_width         = 29;
  localparam int          std_id_lsb       = 18;
  localparam int          mask_low_lsb     = 2;
  localparam int          mask_low_msb     = 6;
  localparam int          dlc_msb          = 3;
  localparam int          first_local_byte = 3;
  localparam int          last_local_byte  = 7;
  localparam logic [7:0]  mask_low_keep    = 8'h7c;
  localparam logic [7:0]  dlc_keep         = 8'h0f;
  localparam logic [7:0]  reg_reset_value  = 8'h00;
  localparam logic [3:0]  dlc_full_length  = 4'h8;

  // register port request from the command decoder
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } reg_req_type;

  // frame as decoded by the can receiver: identifier, format bit, length code and data
  typedef struct packed {
    logic [28:0] id;
    logic        extended_id_select;
    logic [3:0]  dlc;
    logic [63:0] data;
  } rx_frame_type;

endpackage

// ===== test/wake_frame_sender.sv
// partner model: can node handing finished wake-up frames to the block
// assumes go is driven just after a rising edge of clk_sys
`timescale 1ns/10ps
module wake_frame_sender
  import wake_cfg_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         go,
  input  wire rx_frame_type frame_in,
  output rx_frame_type      rx_frame,
  output logic              frame_done
);
  // ****************
  // frame hand-over
  // ****************
  initial begin
    rx_frame   = '0;
    frame_done = 1'b0;
  end
  // only data frames exist in this frame type, no remote request
  // between frames the lines toggle so a stale frame never looks valid
  always @(posedge clk_sys) begin
    frame_done <= go;
    rx_frame   <= go ? frame_in : ~rx_frame;
  end
endmodule

// ===== test/tb_wake_frame_cfg.sv
// testbench: register port, valid flag and frame matching against a bench model
// assumes the package and the frame sender model are compiled before it
`timescale 1ns/10ps
module tb_wake_frame_cfg;
  import wake_cfg_pkg::*;
  logic         clk_sys, srst, restart, config_valid_set, config_valid_flag, go;
  logic         expected_ide, low_bytes_match, frame_done, wake_up_frame_match, mflag, hit;
  logic [7:0]   reg_rdata;
  logic [28:0]  expected_id;
  reg_req_type  reg_req;
  rx_frame_type rx_frame, fr;
  logic [7:0]   m [0:9];
  int           err_count = 0, n_checks = 0, cyc = 0;
  wake_frame_cfg dut (.clk_sys(clk_sys), .srst(srst), .restart(restart), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .config_valid_set(config_valid_set),
    .config_valid_flag(config_valid_flag), .expected_id(expected_id),
    .expected_ide(expected_ide), .low_bytes_match(low_bytes_match),
    .frame_done(frame_done), .rx_frame(rx_frame), .wake_up_frame_match(wake_up_frame_match));
  wake_frame_sender node (.clk_sys(clk_sys), .go(go), .frame_in(fr), .rx_frame(rx_frame),
    .frame_done(frame_done));
  // ****************
  // clock, timeout and helpers
  // ****************
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // a full run takes about 3500 cycles
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc > 20000) begin
      err_count++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // the extra edge after each access keeps strobes from being set twice in one step
  task automatic wr(int a, logic [7:0] d);
    reg_req = '{1'b1, 1'b0, 7'(a), d};
    tick(1);
    reg_req.wr = 1'b0;
    tick(1);
    if (a >= 39 && a <= 48) begin
      d = d & (a == 42 ? mask_low_keep : a == 43 ? dlc_keep : 8'hff);
      if (d !== m[a - 39]) mflag = 1'b0;
      m[a - 39] = d;
    end
  endtask
  task automatic rd(int a);
    reg_req = '{1'b0, 1'b1, 7'(a), 8'h00};
    tick(1);
    reg_req.rd = 1'b0;
    chk(reg_rdata, (a >= 39 && a <= 48) ? m[a - 39] : 8'h00);
    tick(1);
  endtask
  function automatic logic mdl_match(rx_frame_type f);
    logic [28:0] msk;
    logic        ok;
    int          len;
    msk = {m[0], m[1], m[2], m[3][6:2]};
    if (!expected_ide) msk = msk & 29'h1ffc0000;
    len = (f.dlc > 7) ? 8 : int'(f.dlc);
    ok = mflag && f.extended_id_select == expected_ide && ((f.id ^ expected_id) & msk) == 0
         && f.dlc == m[4][3:0] && low_bytes_match;
    for (int n = 3; n < len; n++) if (f.data[8*n +: 8] != m[12 - n]) ok = 1'b0;
    return ok;
  endfunction
  task automatic pulse_set();
    config_valid_set = 1'b1;
    tick(1);
    config_valid_set = 1'b0;
    mflag = 1'b1;
  endtask
  // ****************
  // main sequence
  // ****************
  initial begin
    srst = 1'b1;
    {restart, config_valid_set, go, expected_ide, mflag} = '0;
    {reg_req, fr, expected_id} = '0;
    low_bytes_match = 1'b1;
    foreach (m[k]) m[k] = 8'h00;
    void'($urandom(81366));
    tick(12);
    srst = 1'b0;
    for (int a = 38; a <= 49; a++) rd(a);
    for (int i = 0; i < 64; i++) begin
      for (int a = 38; a <= 49; a++) begin
        wr(a, 8'($urandom()));
        rd(a);
      end
      wr(43, {4'($urandom()), 4'(i)});
      if (i % 5 != 4) pulse_set();
      chk(config_valid_flag, mflag);
      expected_id = 29'($urandom());
      expected_ide = 1'($urandom());
      low_bytes_match = ($urandom_range(7, 0) != 0);
      fr.id = expected_id ^ (($urandom_range(3, 0) == 0) ? 29'h1 << $urandom_range(28, 0) : 29'h0);
      fr.extended_id_select = ($urandom_range(7, 0) == 0) ? ~expected_ide : expected_ide;
      fr.dlc = m[4][3:0] ^ (($urandom_range(3, 0) == 0) ? 4'($urandom_range(15, 1)) : 4'h0);
      fr.data = {$urandom(), $urandom()};
      for (int n = 3; n < 8; n++) if ($urandom_range(7, 0) != 0) fr.data[8*n +: 8] = m[12 - n];
      // the model result is taken before a wake clears the modelled flag
      hit = mdl_match(fr);
      mflag = mflag & !hit;
      chk(wake_up_frame_match, 8'h00);
      go = 1'b1;
      tick(1);
      go = 1'b0;
      tick(1);
      chk(wake_up_frame_match, 8'(hit));
      chk(config_valid_flag, mflag);
      tick(1);
      chk(wake_up_frame_match, 8'h00);
    end
    pulse_set();
    restart = 1'b1;
    tick(1);
    restart = 1'b0;
    mflag = 1'b0;
    chk(config_valid_flag, 8'h00);
    for (int a = 39; a <= 48; a++) rd(a);
    srst = 1'b1;
    tick(2);
    srst = 1'b0;
    foreach (m[k]) m[k] = 8'h00;
    for (int a = 39; a <= 48; a++) rd(a);
    end_of_test();
  end
endmodule
